// [rtl/cda_pkg.sv]
// package for the complement and decimal adjust alu block
// Operation
// - in-place invert: byte inverted, written back, zero flag updated
// - inverse goes to accumulator, memory kept, zero flag updated
// - low nibble above 9 or half carry set adds 6, else unchanged
// - high nibble above 9, carry set, or high nibble 9 with low nibble above 9 adds 6, else unchanged
// - adjust adds exactly 00h, 06h, 60h or 66h to the accumulator
// - decimal adjust result goes to addressed memory, not accumulator
// - decimal adjust touches only carry; set when the accumulator before adjust passes 99 or carry was already set
package cda_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int NIB_LO = 0;
    localparam int NIB_HI = 4;
    localparam logic [3:0] NIB_MAX = 4'h9;
    localparam logic [7:0] ADJ_NONE = 8'h00;
    localparam logic [7:0] ADJ_LO = 8'h06;
    localparam logic [7:0] ADJ_HI = 8'h60;
    localparam logic [7:0] ADJ_BOTH = 8'h66;

    typedef enum logic [1:0] {
        CDA_OP_INVERT_MEMORY_IN_PLACE = 2'b00,
        CDA_OP_INVERT_MEMORY_TO_WORKING = 2'b01,
        CDA_OP_DECIMAL_ADJUST_TO_MEMORY = 2'b10,
        CDA_OP_NONE = 2'b11
    } cda_op_e;

    typedef struct packed {
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } cda_flags_s;

    typedef struct packed {
        logic valid;
        cda_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] mem_data;
        logic [DATA_W-1:0] acc;
        cda_flags_s flags;
    } cda_req_s;

    typedef struct packed {
        logic mem_we;
        logic [ADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] mem_wdata;
        logic acc_we;
        logic [DATA_W-1:0] acc_wdata;
        logic zero_we;
        logic carry_we;
        cda_flags_s flags;
    } cda_res_s;
endpackage

// [rtl/cda_adjust.sv]
// decimal correction term and carry for the decimal adjust operation
`timescale 1ns/100ps
`default_nettype none
module cda_adjust
    import cda_pkg::*;
(
    input wire logic [DATA_W-1:0] acc_in,
    input wire logic half_carry_in,
    input wire logic carry_in,
    output logic [DATA_W-1:0] result_out,
    output logic carry_out
);
    wire logic [3:0] lo_nib = acc_in[NIB_LO +: 4];
    wire logic [3:0] hi_nib = acc_in[NIB_HI +: 4];
    wire logic fix_lo = (lo_nib > NIB_MAX) || half_carry_in;
    // the low fix can ripple a 9 up to 10, so the high test uses that case
    wire logic lo_ripple = fix_lo && (lo_nib > NIB_MAX) && (hi_nib == NIB_MAX);
    wire logic fix_hi = (hi_nib > NIB_MAX) || carry_in || lo_ripple;
    wire logic [7:0] adj = fix_hi ? (fix_lo ? ADJ_BOTH : ADJ_HI)
                                  : (fix_lo ? ADJ_LO : ADJ_NONE);
    wire logic [8:0] sum = {1'b0, acc_in} + {1'b0, adj};
    assign result_out = sum[7:0];
    assign carry_out = carry_in || sum[8] || fix_hi;
endmodule
`default_nettype wire

// [rtl/cda_alu.sv]
// complement and decimal adjust alu datapath stage
`timescale 1ns/100ps
`default_nettype none
module cda_alu
    import cda_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire cda_req_s req_in,
    output cda_res_s res_out,
    output logic res_valid_out
);
    ////////////////////////////////////////////////////////////////////////
    // operation decode
    // one function serves all three selects so they stay mutually exclusive
    function automatic logic op_hit(input cda_req_s r, input cda_op_e o);
        return r.valid && (r.op == o);
    endfunction

    wire logic is_inv_mem = op_hit(req_in, CDA_OP_INVERT_MEMORY_IN_PLACE);
    wire logic is_inv_acc = op_hit(req_in, CDA_OP_INVERT_MEMORY_TO_WORKING);
    wire logic is_adjust = op_hit(req_in, CDA_OP_DECIMAL_ADJUST_TO_MEMORY);
    // the none code and an idle request take nothing and write nothing
    wire logic is_taken = is_inv_mem || is_inv_acc || is_adjust;

    ////////////////////////////////////////////////////////////////////////
    // bitwise inverse, one cell per data bit
    wire logic [DATA_W-1:0] inverted;
    for (genvar b = 0; b < DATA_W; b++) begin : g_inv
        assign inverted[b] = ~req_in.mem_data[b];
    end
    // zero test shared by both invert forms
    wire logic inv_zero = (inverted == '0);

    ////////////////////////////////////////////////////////////////////////
    // decimal correction sits in its own module so it can be checked alone
    wire logic [DATA_W-1:0] adj_result;
    wire logic adj_carry;

    cda_adjust cda_adjust_inst (
        .acc_in(req_in.acc),
        .half_carry_in(req_in.flags.half_carry_flag),
        .carry_in(req_in.flags.carry_flag),
        .result_out(adj_result),
        .carry_out(adj_carry)
    );

    ////////////////////////////////////////////////////////////////////////
    // result selection; flags pass through so the caller may write them all
    // back, but only fields with their enable high are meant to change
    cda_res_s res_nxt;
    always_comb begin
        res_nxt = '0;
        res_nxt.mem_addr = req_in.addr;
        res_nxt.flags = req_in.flags;
        case (1'b1)
            is_inv_mem: begin
                res_nxt.mem_we = 1'b1;
                res_nxt.mem_wdata = inverted;
                res_nxt.zero_we = 1'b1;
                res_nxt.flags.zero_flag = inv_zero;
            end
            is_inv_acc: begin
                res_nxt.acc_we = 1'b1;
                res_nxt.acc_wdata = inverted;
                res_nxt.zero_we = 1'b1;
                res_nxt.flags.zero_flag = inv_zero;
            end
            is_adjust: begin
                res_nxt.mem_we = 1'b1;
                res_nxt.mem_wdata = adj_result;
                res_nxt.carry_we = 1'b1;
                res_nxt.flags.carry_flag = adj_carry;
            end
            default: begin
                res_nxt.mem_we = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // one registered stage; results land the cycle after the request
    // the caller must consume res_out in that cycle: it is not held
    // reset clears every enable so nothing is written while the core restarts
    cda_res_s res_r;
    logic valid_r;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            res_r <= '0;
            valid_r <= 1'b0;
        end else begin
            res_r <= res_nxt;
            valid_r <= is_taken;
        end
    end
    assign res_out = res_r;
    assign res_valid_out = valid_r;

    ////////////////////////////////////////////////////////////////////////
    // checks on the registered result, one cycle after each request
    default clocking cb_sys @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    // invert forms
    a_inplace_invert: assert property (
        is_inv_mem |=> res_out.mem_we && !res_out.acc_we &&
            res_out.mem_wdata == ~$past(req_in.mem_data) &&
            res_out.mem_addr == $past(req_in.addr))
        else $error("in-place invert result wrong");

    a_working_invert: assert property (
        is_inv_acc |=> res_out.acc_we && !res_out.mem_we &&
            res_out.acc_wdata == ~$past(req_in.mem_data))
        else $error("invert to working result wrong");

    a_inplace_zero: assert property (
        is_inv_mem |=> res_out.zero_we &&
            res_out.flags.zero_flag == ($past(req_in.mem_data) == 8'hff))
        else $error("zero flag wrong after in-place invert");

    a_working_zero: assert property (
        is_inv_acc |=> res_out.zero_we && !res_out.carry_we &&
            res_out.flags.zero_flag == ($past(req_in.mem_data) == 8'hff))
        else $error("zero flag wrong after invert to working");

    // decimal adjust nibble rules
    a_low_fix: assert property (
        is_adjust &&
            (req_in.acc[3:0] > 4'h9 || req_in.flags.half_carry_flag)
        |=> res_out.mem_wdata[3:0] == $past(req_in.acc[3:0]) + 4'h6)
        else $error("low nibble fix missing");

    a_low_pass: assert property (
        is_adjust && req_in.acc[3:0] <= 4'h9 &&
            !req_in.flags.half_carry_flag
        |=> res_out.mem_wdata[3:0] == $past(req_in.acc[3:0]))
        else $error("low nibble changed");

    a_low_wrap: assert property (
        is_adjust && req_in.acc[3:0] > 4'h9
        |=> res_out.mem_wdata[3:0] <= 4'h5)
        else $error("low nibble left outside decimal range");

    a_high_fix: assert property (
        is_adjust && req_in.flags.carry_flag && req_in.acc[3:0] <= 4'h9 &&
            !req_in.flags.half_carry_flag
        |=> res_out.mem_wdata == $past(req_in.acc) + 8'h60)
        else $error("high nibble fix missing");

    a_high_plain: assert property (
        is_adjust && !req_in.flags.carry_flag &&
            !req_in.flags.half_carry_flag &&
            req_in.acc[7:4] <= 4'h9 && req_in.acc[3:0] <= 4'h9
        |=> res_out.mem_wdata == $past(req_in.acc))
        else $error("high nibble changed without cause");

    a_both_fix: assert property (
        is_adjust && req_in.flags.carry_flag &&
            req_in.flags.half_carry_flag
        |=> res_out.mem_wdata == $past(req_in.acc) + 8'h66)
        else $error("combined fix missing");

    a_adjust_set: assert property (
        is_adjust |=> (res_out.mem_wdata - $past(req_in.acc)) inside
            {8'h00, 8'h06, 8'h60, 8'h66})
        else $error("adjust constant outside set");

    a_nibble_split: assert property (
        is_adjust && req_in.acc == 8'h9a && !req_in.flags.carry_flag &&
            !req_in.flags.half_carry_flag
        |=> res_out.mem_wdata == 8'h00 && res_out.flags.carry_flag)
        else $error("nibble ripple handling wrong");

    // carry and flag rules
    a_adjust_target: assert property (
        is_adjust |=> res_out.mem_we && !res_out.acc_we &&
            !res_out.zero_we && res_out.carry_we)
        else $error("decimal adjust target or flags wrong");

    a_adjust_addr: assert property (
        is_adjust |=> res_out.mem_addr == $past(req_in.addr))
        else $error("decimal adjust address wrong");

    a_carry_sticky: assert property (
        is_adjust && (req_in.flags.carry_flag || req_in.acc > 8'h99)
        |=> res_out.flags.carry_flag)
        else $error("carry not set after decimal adjust");

    a_carry_clear: assert property (
        is_adjust && !req_in.flags.carry_flag && req_in.acc < 8'h9a
        |=> !res_out.flags.carry_flag)
        else $error("carry set without decimal overflow");

    a_flags_kept: assert property (
        is_adjust |=> res_out.flags.half_carry_flag ==
            $past(req_in.flags.half_carry_flag) &&
            res_out.flags.zero_flag == $past(req_in.flags.zero_flag))
        else $error("decimal adjust changed another flag");

    // result strobes
    a_valid_follows: assert property (
        is_taken |=> res_valid_out)
        else $error("result strobe missing");

    a_idle_quiet: assert property (
        !is_taken |=> !res_valid_out && !res_out.mem_we &&
            !res_out.acc_we && !res_out.zero_we && !res_out.carry_we)
        else $error("write enable without a request");

    a_single_target: assert property (
        res_valid_out |-> res_out.mem_we != res_out.acc_we)
        else $error("result must write exactly one target");

    a_carry_only: assert property (
        res_out.carry_we |-> !res_out.zero_we && res_out.mem_we)
        else $error("carry write paired with wrong target");
endmodule
`default_nettype wire

// [test/cda_partner.sv]
// data memory and request source standing in for the decoder
`timescale 1ns/100ps
`default_nettype none
module cda_partner
    import cda_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic go_in,
    input wire cda_op_e op_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] acc_in,
    input wire cda_flags_s flags_in,
    input wire cda_res_s res_in,
    output cda_req_s req_out
);
    logic [DATA_W-1:0] mem_r [0:255];
    logic [DATA_W-1:0] rd;
    initial begin
        for (int i = 0; i < 256; i++) mem_r[i] = i[7:0];
    end
    // idle read data is inverted so a stale byte never looks fresh
    assign rd = go_in ? mem_r[addr_in] : ~mem_r[addr_in];
    assign req_out = {go_in, op_in, addr_in, rd, acc_in, flags_in};
    always @(posedge clk_sys_in) begin
        if (res_in.mem_we) mem_r[res_in.mem_addr] <= res_in.mem_wdata;
    end
endmodule
`default_nettype wire

// [test/complement_decimal_adjust_alu_tb.sv]
// self-checking bench for the complement and decimal adjust alu
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    err_total++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module complement_decimal_adjust_alu_tb;
    import cda_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic go = 1'b0;
    cda_op_e op = CDA_OP_NONE;
    logic [7:0] addr = 8'h00;
    logic [7:0] acc = 8'h00;
    cda_flags_s flags = 3'b000;
    cda_req_s req;
    cda_res_s res;
    logic res_valid;
    int err_total = 0;
    int samples_checked = 0;
    cda_alu cda_alu_inst(.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .req_in(req), .res_out(res), .res_valid_out(res_valid));
    cda_partner cda_partner_inst(.clk_sys_in(clk_sys_in), .go_in(go),
        .op_in(op), .addr_in(addr), .acc_in(acc), .flags_in(flags),
        .res_in(res), .req_out(req));
    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // answer lands one edge after the request is taken
    task automatic issue(input cda_op_e o, input logic [7:0] a,
        input logic [7:0] c, input cda_flags_s f);
        @(posedge clk_sys_in);
        #1;
        go = 1'b1;
        op = o;
        addr = a;
        acc = c;
        flags = f;
        @(posedge clk_sys_in);
        #1;
        go = 1'b0;
    endtask
    function automatic logic [8:0] adjust_ref(input logic [7:0] a,
        input logic h, input logic c);
        logic [8:0] s;
        logic hi;
        s = (a[3:0] > 4'h9 || h) ? 9'h006 : 9'h000;
        s = s + {1'b0, a};
        hi = s[7:4] > 4'h9 || c || s[8];
        s = s + (hi ? 9'h060 : 9'h000);
        return {c | hi | s[8], s[7:0]};
    endfunction
    task automatic t_invert();
        issue(CDA_OP_INVERT_MEMORY_IN_PLACE, 8'hff, 8'h00, 3'b000);
        `CHK(res_valid, 1'b1)
        `CHK({res.mem_we, res.mem_addr, res.mem_wdata}, 17'h1ff00)
        `CHK({res.acc_we, res.zero_we, res.flags.zero_flag}, 3'b011)
        issue(CDA_OP_INVERT_MEMORY_TO_WORKING, 8'hff, 8'h00, 3'b000);
        `CHK({res.mem_we, res.acc_we, res.acc_wdata}, 10'h1ff)
        `CHK({res.zero_we, res.flags.zero_flag}, 2'b10)
        issue(CDA_OP_INVERT_MEMORY_TO_WORKING, 8'h5a, 8'h00, 3'b000);
        `CHK({res.mem_we, res.acc_we, res.acc_wdata}, 10'h1a5)
        $display("invert test done");
    endtask
    task automatic t_daa();
        logic [7:0] v [6] = '{8'h15, 8'h9a, 8'h0b, 8'ha3, 8'h99, 8'h38};
        logic [8:0] e;
        for (int i = 0; i < 24; i++) begin
            e = adjust_ref(v[i/4], i[1], i[0]);
            issue(CDA_OP_DECIMAL_ADJUST_TO_MEMORY, 8'h40, v[i/4],
                {1'b0, i[1], i[0]});
            `CHK(res.mem_we, 1'b1)
            `CHK({res.mem_addr, res.mem_wdata}, {8'h40, e[7:0]})
            `CHK({res.acc_we, res.zero_we, res.carry_we}, 3'b001)
            `CHK(res.flags.carry_flag, e[8])
        end
        $display("decimal adjust test done");
    endtask
    task automatic t_stream();
        @(posedge clk_sys_in);
        #1;
        go = 1'b1;
        op = CDA_OP_INVERT_MEMORY_TO_WORKING;
        addr = 8'h10;
        @(posedge clk_sys_in);
        #1;
        addr = 8'h11;
        `CHK({res_valid, res.acc_we, res.acc_wdata}, 10'h3ef)
        @(posedge clk_sys_in);
        #1;
        go = 1'b0;
        `CHK({res_valid, res.acc_we, res.acc_wdata}, 10'h3ee)
        @(posedge clk_sys_in);
        #1;
        `CHK({res_valid, res.acc_we}, 2'b00)
        $display("back to back test done");
    endtask
    task automatic t_reset();
        @(posedge clk_sys_in);
        #1;
        go = 1'b1;
        op = CDA_OP_INVERT_MEMORY_IN_PLACE;
        addr = 8'h20;
        rst_in = 1'b1;
        @(posedge clk_sys_in);
        #1;
        go = 1'b0;
        `CHK({res_valid, res}, 32'h0)
        @(posedge clk_sys_in);
        #1;
        rst_in = 1'b0;
        `CHK({res_valid, res}, 32'h0)
        issue(CDA_OP_INVERT_MEMORY_TO_WORKING, 8'h20, 8'h00, 3'b000);
        `CHK({res_valid, res.acc_wdata}, 9'h1df)
        $display("reset test done");
    endtask
    task automatic t_refuse();
        issue(CDA_OP_NONE, 8'h10, 8'h00, 3'b000);
        `CHK({res_valid, res.mem_we, res.acc_we, res.zero_we}, 4'h0)
        $display("refuse test done");
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys_in);
        #1 rst_in = 1'b0;
        t_invert();
        t_daa();
        t_stream();
        t_refuse();
        t_reset();
        final_report();
    end
    initial begin
        #200000;
        err_total++;
        final_report();
    end
endmodule
`default_nettype wire
